/* apc_pkg.sv */
/*
  Constants for the auto powerdown controller: floppy register offsets,
  control bit positions, parallel port modes and the powerdown timer.
  Assumes a 100 MHz device clock.
*/
package apc_pkg;
  localparam logic [2:0] APC_OFF_STAT_A = 3'h0;
  localparam logic [2:0] APC_OFF_STAT_B = 3'h1;
  localparam logic [2:0] APC_OFF_DOC = 3'h2;
  localparam logic [2:0] APC_OFF_RATE_MAIN = 3'h4;
  localparam logic [2:0] APC_OFF_FIFO = 3'h5;
  localparam logic [2:0] APC_OFF_DIN_XFER = 3'h7;
  localparam logic [7:0] APC_MAIN_IDLE = 8'h80;
  localparam int APC_DOC_RESETN_BIT = 2;
  localparam int APC_DOC_MOTOR_LO = 4;
  localparam int APC_RATE_SWRST_BIT = 7;
  localparam int APC_CFG_FDC_BIT = 0;
  localparam int APC_CFG_PAR_BIT = 3;
  localparam int APC_CFG_UA1_BIT = 4;
  localparam int APC_CFG_UA2_BIT = 5;
  localparam int APC_SMI_SERIRQ_BIT = 6;
  localparam int APC_SMI_PIN_BIT = 7;
  localparam logic [7:0] APC_DOC_RESET = 8'h04;
  localparam logic [7:0] APC_RATE_RESET = 8'h02;
  localparam logic [7:0] APC_XFER_RESET = 8'h00;
  localparam int APC_CLK_MHZ = 100;
  localparam int APC_PD_TIME_MS = 10;
  localparam int APC_PD_CYCLES = APC_PD_TIME_MS * 1000 * APC_CLK_MHZ;
  // Extended control register modes
  localparam logic [2:0] APC_ECR_SPP = 3'h0;
  localparam logic [2:0] APC_ECR_BIDIR = 3'h1;
  localparam logic [2:0] APC_ECR_EPP = 3'h4;
endpackage : apc_pkg

/* apc_sync2.sv */
/*
  Two flip-flop synchroniser for asynchronous pin inputs.
  Assumes the sampled pin may change at any time.
*/
`timescale 1ns/1ps
module apc_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] nxt_s1;
  logic [W-1:0] nxt_q;
  always_comb begin
    nxt_s1 = resetn ? d : '0;
    nxt_q = resetn ? s1_ff : '0;
  end
  always_ff @(posedge clock) begin
    s1_ff <= nxt_s1;
    q <= nxt_q;
  end
endmodule : apc_sync2

/* apc_uart_pd.sv */
/*
  Auto powerdown tracker for one UART: transmitter and receiver states
  and the ring indicator change flag. Assumes synchronised serial inputs.
*/
`timescale 1ns/1ps
module apc_uart_pd (
  input wire logic clock,
  input wire logic resetn,
  input wire logic enable,
  input wire logic thr_write,
  input wire logic tx_empty,
  input wire logic rx_fifo_empty,
  input wire logic rx_idle,
  input wire logic rx_sync,
  input wire logic ri_sync,
  output logic tx_pd,
  output logic rx_pd,
  output logic ri_change
);
  logic tx_ff, rx_ff, rxl_ff, ril_ff, ric_ff;
  logic nxt_tx, nxt_rx, nxt_rxl, nxt_ril, nxt_ric;
  logic rx_edge;
  always_comb begin
    rx_edge = rx_sync != rxl_ff;
    nxt_rxl = rx_sync;
    nxt_ril = ri_sync;
    nxt_ric = ri_sync != ril_ff;
    nxt_tx = enable && tx_empty && !thr_write;
    nxt_rx = enable && rx_fifo_empty && rx_idle && !rx_edge;
    if (!resetn) begin
      nxt_tx = 1'b0;
      nxt_rx = 1'b0;
      nxt_ric = 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    tx_ff <= nxt_tx;
    rx_ff <= nxt_rx;
    rxl_ff <= nxt_rxl;
    ril_ff <= nxt_ril;
    ric_ff <= nxt_ric;
  end
  assign tx_pd = tx_ff;
  assign rx_pd = rx_ff;
  assign ri_change = ric_ff;

  a_tx_wake: assert property (@(posedge clock) disable iff (!resetn)
    thr_write |=> !tx_pd) else $error("tx stayed down after write");
  a_rx_wake: assert property (@(posedge clock) disable iff (!resetn)
    (rx_sync != $past(rx_sync)) |=> !rx_pd)
    else $error("rx stayed down after edge");
  a_ri_live: assert property (@(posedge clock) disable iff (!resetn)
    $changed(ri_sync) |-> ##1 ri_change)
    else $error("ri change missed");
endmodule : apc_uart_pd

/* apc_top.sv */
/*
  Auto powerdown controller: floppy wake decode and timer, floppy drive
  pin gating, UART and parallel port powerdown, SYS_MGMT_IRQ routing.
  Assumes a host I/O strobe pair on the device clock and status from the
  floppy core, UARTs and parallel port logic.
*/
`timescale 1ns/1ps
// How it works
// - Main status read or any data port access wakes floppy
// - Control or rate writes wake only on motor enable or software reset
// - Host inputs stay live; irq and dma request held low asleep
// - Motor, select, write data, write gate tristated asleep; others driven
// - UART powerdown allowed only when its own config bit set: bit four for the first UART, bit five for the second
// - Transmitter sleeps when holding buffer and shift register empty
// - Receiver sleeps only with empty FIFO while awaiting a start bit
// - Ring indicator change flag keeps working in powerdown
// - Holding buffer write wakes transmitter
// - Receive line level change wakes receiver
// - Parallel powerdown allowed only when config bit three set
// - EPP down when disabled or ECP active without EPP mode
// - ECP down when disabled or register selects STANDARD_PARALLEL_MODE, bidir or EPP
// - Parallel power state recomputed on any mode change
// - SYS_MGMT_IRQ routed to serial IRQ by bit six, to pin by bit seven
// - Floppy sleeps after motors off, idle, head unloaded, 10 ms timer
// - Config bit zero enables floppy sleep; clearing cancels timer
// - Wake by access restarts the 10 ms timer, state kept
// - Non-waking writes during sleep are kept in registers
module apc_top
  import apc_pkg::*;
#(
  parameter int PD_CYCLES = APC_PD_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic [2:0] sys_addr,
  input wire logic [7:0] sys_data_in,
  output logic [7:0] sys_data_out,
  output logic sys_data_oe,
  input wire logic bus_reset,
  input wire logic [7:0] auto_power_cfg,
  input wire logic [7:0] smi_enable2,
  input wire logic smi_event,
  output logic smi_to_serirq,
  output logic sys_mgmt_irq,
  input wire logic [7:0] core_main_status,
  input wire logic [7:0] core_stat_a,
  input wire logic [7:0] core_stat_b,
  input wire logic [7:0] core_din,
  input wire logic core_int,
  input wire logic core_drq,
  input wire logic head_unloaded,
  output logic irq_out,
  output logic dma_req,
  output logic [7:0] doc_value,
  output logic [7:0] rate_value,
  output logic [7:0] xfer_value,
  output logic fdc_wake_pulse,
  output logic fdc_soft_reset,
  output logic fdc_powered_down,
  input wire logic [1:0] core_motor_on_n,
  input wire logic [1:0] core_drive_sel_n,
  input wire logic core_write_stream_n,
  input wire logic core_write_gate_n,
  output logic [1:0] motor_on_n,
  output logic [1:0] motor_on_oe,
  output logic [1:0] drive_sel_n,
  output logic [1:0] drive_sel_oe,
  output logic write_stream_n,
  output logic write_stream_oe,
  output logic write_gate_n,
  output logic write_gate_oe,
  input wire logic [1:0] thr_write,
  input wire logic [1:0] tx_empty,
  input wire logic [1:0] rx_fifo_empty,
  input wire logic [1:0] rx_idle,
  input wire logic [1:0] serial_rx_in,
  input wire logic [1:0] ring_indicator,
  output logic [1:0] uart_tx_pd,
  output logic [1:0] uart_rx_pd,
  output logic [1:0] ring_change,
  input wire logic epp_enabled,
  input wire logic ecp_enabled,
  input wire logic [2:0] ecr_mode,
  output logic epp_pd,
  output logic ecp_pd
);
  localparam logic [23:0] PD_LAST = 24'(PD_CYCLES - 1);

  logic rd_ff, wr_ff, nxt_rd, nxt_wr;
  logic [7:0] doc_ff, rate_ff, xfer_ff, dout_ff;
  logic [7:0] nxt_doc, nxt_rate, nxt_xfer, nxt_dout;
  logic doe_ff, nxt_doe, wake_ff, nxt_wake, srst_ff, nxt_srst;
  logic pd_ff, nxt_pd;
  logic [23:0] tmr_ff, nxt_tmr;
  logic epp_ff, ecp_ff, nxt_epp, nxt_ecp;
  logic smis_ff, smip_ff, nxt_smis, nxt_smip;
  logic rd_go, wr_go, wake, doc_wr, rate_wr, tmr_done, cond_ok;
  logic [1:0] rx_s, ri_s;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction : hit

  apc_sync2 #(.W(4)) u_sync (
    .clock(clock),
    .resetn(resetn),
    .d({serial_rx_in, ring_indicator}),
    .q({rx_s, ri_s})
  );

  always_comb begin
    rd_go = !io_read_strobe_n && !rd_ff;
    wr_go = !io_write_strobe_n && !wr_ff;
    doc_wr = wr_go && hit(sys_addr, APC_OFF_DOC);
    rate_wr = wr_go && hit(sys_addr, APC_OFF_RATE_MAIN);
    wake = (rd_go && hit(sys_addr, APC_OFF_RATE_MAIN))
      || ((rd_go || wr_go) && hit(sys_addr, APC_OFF_FIFO))
      || (doc_wr && (sys_data_in[APC_DOC_MOTOR_LO +: 4] != 4'h0))
      || (doc_wr && !sys_data_in[APC_DOC_RESETN_BIT])
      || (rate_wr && sys_data_in[APC_RATE_SWRST_BIT])
      || bus_reset;
    nxt_rd = !io_read_strobe_n;
    nxt_wr = !io_write_strobe_n;
    nxt_doc = doc_wr ? sys_data_in : doc_ff;
    nxt_rate = rate_wr ? sys_data_in : rate_ff;
    nxt_xfer = (wr_go && hit(sys_addr, APC_OFF_DIN_XFER)) ? sys_data_in
      : xfer_ff;
    nxt_doe = !io_read_strobe_n;
    unique case (sys_addr)
      APC_OFF_STAT_A: nxt_dout = core_stat_a;
      APC_OFF_STAT_B: nxt_dout = core_stat_b;
      APC_OFF_DOC: nxt_dout = doc_ff;
      APC_OFF_RATE_MAIN: nxt_dout = core_main_status;
      APC_OFF_DIN_XFER: nxt_dout = core_din;
      default: nxt_dout = 8'h00;
    endcase
    nxt_wake = wake;
    nxt_srst = (doc_wr && !sys_data_in[APC_DOC_RESETN_BIT])
      || (rate_wr && sys_data_in[APC_RATE_SWRST_BIT]);
    tmr_done = (tmr_ff == PD_LAST);
    cond_ok = (doc_ff[APC_DOC_MOTOR_LO +: 4] == 4'h0)
      && (core_main_status == APC_MAIN_IDLE) && !core_int
      && head_unloaded && tmr_done;
    if (!auto_power_cfg[APC_CFG_FDC_BIT] || wake) begin
      nxt_tmr = 24'h000000;
      nxt_pd = 1'b0;
    end else begin
      nxt_tmr = tmr_done ? tmr_ff : tmr_ff + 24'h000001;
      nxt_pd = pd_ff || cond_ok;
    end
    nxt_epp = auto_power_cfg[APC_CFG_PAR_BIT]
      && (!epp_enabled || (ecp_enabled && ecr_mode != APC_ECR_EPP));
    nxt_ecp = auto_power_cfg[APC_CFG_PAR_BIT] && (!ecp_enabled
      || ecr_mode == APC_ECR_SPP || ecr_mode == APC_ECR_BIDIR
      || ecr_mode == APC_ECR_EPP);
    nxt_smis = smi_event && smi_enable2[APC_SMI_SERIRQ_BIT];
    nxt_smip = smi_event && smi_enable2[APC_SMI_PIN_BIT];
    if (!resetn) begin
      nxt_rd = 1'b0;
      nxt_wr = 1'b0;
      nxt_doc = APC_DOC_RESET;
      nxt_rate = APC_RATE_RESET;
      nxt_xfer = APC_XFER_RESET;
      nxt_dout = 8'h00;
      nxt_doe = 1'b0;
      nxt_wake = 1'b0;
      nxt_srst = 1'b0;
      nxt_tmr = 24'h000000;
      nxt_pd = 1'b0;
      nxt_epp = 1'b0;
      nxt_ecp = 1'b0;
      nxt_smis = 1'b0;
      nxt_smip = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    rd_ff <= nxt_rd;
    wr_ff <= nxt_wr;
    doc_ff <= nxt_doc;
    rate_ff <= nxt_rate;
    xfer_ff <= nxt_xfer;
    dout_ff <= nxt_dout;
    doe_ff <= nxt_doe;
    wake_ff <= nxt_wake;
    srst_ff <= nxt_srst;
    tmr_ff <= nxt_tmr;
    pd_ff <= nxt_pd;
    epp_ff <= nxt_epp;
    ecp_ff <= nxt_ecp;
    smis_ff <= nxt_smis;
    smip_ff <= nxt_smip;
  end

  for (genvar i = 0; i < 2; i++) begin : g_uart
    apc_uart_pd u_pd (
      .clock(clock),
      .resetn(resetn),
      .enable(auto_power_cfg[APC_CFG_UA1_BIT + i]),
      .thr_write(thr_write[i]),
      .tx_empty(tx_empty[i]),
      .rx_fifo_empty(rx_fifo_empty[i]),
      .rx_idle(rx_idle[i]),
      .rx_sync(rx_s[i]),
      .ri_sync(ri_s[i]),
      .tx_pd(uart_tx_pd[i]),
      .rx_pd(uart_rx_pd[i]),
      .ri_change(ring_change[i])
    );
  end

  assign sys_data_out = dout_ff;
  assign sys_data_oe = doe_ff;
  assign irq_out = core_int && !pd_ff;
  assign dma_req = core_drq && !pd_ff;
  assign doc_value = doc_ff;
  assign rate_value = rate_ff;
  assign xfer_value = xfer_ff;
  assign fdc_wake_pulse = wake_ff;
  assign fdc_soft_reset = srst_ff;
  assign fdc_powered_down = pd_ff;
  assign motor_on_n = core_motor_on_n;
  assign motor_on_oe = {2{!pd_ff}};
  assign drive_sel_n = core_drive_sel_n;
  assign drive_sel_oe = {2{!pd_ff}};
  assign write_stream_n = core_write_stream_n;
  assign write_stream_oe = !pd_ff;
  assign write_gate_n = core_write_gate_n;
  assign write_gate_oe = !pd_ff;
  assign epp_pd = epp_ff;
  assign ecp_pd = ecp_ff;
  assign smi_to_serirq = smis_ff;
  assign sys_mgmt_irq = smip_ff;

  a_wake_fdc: assert property (@(posedge clock) disable iff (!resetn)
    wake |=> !fdc_powered_down) else $error("wake ignored");
  a_cfg_off: assert property (@(posedge clock) disable iff (!resetn)
    !auto_power_cfg[APC_CFG_FDC_BIT] |=> !fdc_powered_down && tmr_ff == 0)
    else $error("floppy slept while disabled");
  a_stat_nowake: assert property (@(posedge clock) disable iff (!resetn)
    rd_go && sys_addr == APC_OFF_STAT_A && !wr_go && !bus_reset |-> !wake)
    else $error("status read woke floppy");
  a_sleep_cond: assert property (@(posedge clock) disable iff (!resetn)
    $rose(fdc_powered_down) |-> $past(tmr_done) && $past(head_unloaded))
    else $error("slept before timer");
  a_pins_tri: assert property (@(posedge clock) disable iff (!resetn)
    fdc_powered_down |-> !write_gate_oe && motor_on_oe == 2'b00 && !irq_out)
    else $error("drive pins driven asleep");
  a_keep_write: assert property (@(posedge clock) disable iff (!resetn)
    fdc_powered_down && rate_wr && !sys_data_in[7] |=> rate_ff == $past(sys_data_in))
    else $error("write lost asleep");
  a_smi_pin: assert property (@(posedge clock) disable iff (!resetn)
    smi_event && smi_enable2[7] |=> sys_mgmt_irq)
    else $error("smi pin not routed");
  a_ecp_spp: assert property (@(posedge clock) disable iff (!resetn)
    auto_power_cfg[3] && ecr_mode == APC_ECR_SPP |=> ecp_pd)
    else $error("ecp awake in spp");
  a_irq_quiet: assert property (@(posedge clock) disable iff (!resetn)
    fdc_powered_down |-> !irq_out && !dma_req)
    else $error("irq or dma request raised asleep");
  a_drv_pins: assert property (@(posedge clock) disable iff (!resetn)
    !fdc_powered_down |-> motor_on_oe == 2'b11 && drive_sel_oe == 2'b11)
    else $error("drive pins released while awake");
  a_fifo_wake: assert property (@(posedge clock) disable iff (!resetn)
    (rd_go || wr_go) && sys_addr == APC_OFF_FIFO |=> !fdc_powered_down)
    else $error("data port access left floppy asleep");
  a_motor_wake: assert property (@(posedge clock) disable iff (!resetn)
    doc_wr && sys_data_in[7:4] != 4'h0 |=> !fdc_powered_down)
    else $error("motor enable write left floppy asleep");
  a_par_gate: assert property (@(posedge clock) disable iff (!resetn)
    !auto_power_cfg[APC_CFG_PAR_BIT] |=> !epp_pd && !ecp_pd)
    else $error("parallel logic down while disabled");
  a_epp_off: assert property (@(posedge clock) disable iff (!resetn)
    auto_power_cfg[APC_CFG_PAR_BIT] && !epp_enabled |=> epp_pd)
    else $error("epp awake while not enabled");
  a_smi_serirq: assert property (@(posedge clock) disable iff (!resetn)
    smi_event && smi_enable2[APC_SMI_SERIRQ_BIT] |=> smi_to_serirq)
    else $error("smi not routed to serial irq");
  a_tmr_restart: assert property (@(posedge clock) disable iff (!resetn)
    wake |=> tmr_ff == 24'h000000)
    else $error("timer not restarted on wake");
endmodule : apc_top

/* apc_host_model.sv */
/*
  Host bus master model: byte reads and writes on the strobe pair.
  Assumes the design samples strobes on the rising clock edge.
*/
`timescale 1ns/1ps
module apc_host_model (
  input wire logic clock,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic [2:0] sys_addr,
  output logic [7:0] sys_data_in,
  input wire logic [7:0] sys_data_out
);
  initial begin
    io_read_strobe_n = 1'b1;
    io_write_strobe_n = 1'b1;
    sys_addr = 3'h0;
    sys_data_in = 8'h00;
  end
  // One access: strobe held for three edges, then released with two idle
  task automatic io_acc(input logic wr, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    sys_addr <= a;
    sys_data_in <= d;
    io_write_strobe_n <= ~wr;
    io_read_strobe_n <= wr;
    repeat (3) @(posedge clock);
    q = sys_data_out;
    io_read_strobe_n <= 1'b1;
    io_write_strobe_n <= 1'b1;
    sys_addr <= ~a;
    sys_data_in <= ~d;
    repeat (2) @(posedge clock);
  endtask : io_acc
endmodule : apc_host_model

/* tb_top.sv */
/*
  Self-checking bench for the auto powerdown controller.
  Assumes a short powerdown timer set through PD_CYCLES.
*/
`timescale 1ns/1ps
module tb_top;
  import apc_pkg::*;
  logic clock, resetn, rs_n, ws_n, bus_reset, smi_event, core_int, core_drq;
  logic head_unloaded, core_write_stream_n, core_write_gate_n;
  logic epp_enabled, ecp_enabled, smi_to_serirq, sys_mgmt_irq, sys_data_oe;
  logic irq_out, dma_req, fdc_wake_pulse, fdc_soft_reset, fdc_powered_down;
  logic write_stream_n, write_stream_oe, write_gate_n, write_gate_oe;
  logic epp_pd, ecp_pd;
  logic [2:0] sys_addr, ecr_mode;
  logic [7:0] sys_data_in, sys_data_out, auto_power_cfg, smi_enable2;
  logic [7:0] doc_value, rate_value, xfer_value, q;
  logic [1:0] core_motor_on_n, core_drive_sel_n, motor_on_n, motor_on_oe;
  logic [1:0] drive_sel_n, drive_sel_oe, thr_write, tx_empty, rx_fifo_empty;
  logic [1:0] rx_idle, serial_rx_in, ring_indicator, uart_tx_pd, uart_rx_pd;
  logic [1:0] ring_change;
  int err_count, n_compared, n_wake, n_srst, n_oe;
  initial begin
    n_wake = 0;
    n_srst = 0;
    n_oe = 0;
  end
  always @(negedge clock) begin
    if (fdc_wake_pulse) n_wake++;
    if (fdc_soft_reset) n_srst++;
    if (sys_data_oe) n_oe++;
  end
  apc_top #(.PD_CYCLES(20)) apc_top_inst (.clock(clock), .resetn(resetn),
    .io_read_strobe_n(rs_n), .io_write_strobe_n(ws_n), .sys_addr(sys_addr),
    .sys_data_in(sys_data_in), .sys_data_out(sys_data_out),
    .sys_data_oe(sys_data_oe), .bus_reset(bus_reset),
    .auto_power_cfg(auto_power_cfg), .smi_enable2(smi_enable2),
    .smi_event(smi_event), .smi_to_serirq(smi_to_serirq),
    .sys_mgmt_irq(sys_mgmt_irq), .core_main_status(APC_MAIN_IDLE),
    .core_stat_a(8'ha5), .core_stat_b(8'hb6), .core_din(8'hc7),
    .core_int(core_int), .core_drq(core_drq), .head_unloaded(head_unloaded),
    .irq_out(irq_out), .dma_req(dma_req), .doc_value(doc_value),
    .rate_value(rate_value), .xfer_value(xfer_value),
    .fdc_wake_pulse(fdc_wake_pulse), .fdc_soft_reset(fdc_soft_reset),
    .fdc_powered_down(fdc_powered_down), .core_motor_on_n(core_motor_on_n),
    .core_drive_sel_n(core_drive_sel_n), .core_write_gate_n(core_write_gate_n),
    .core_write_stream_n(core_write_stream_n), .motor_on_n(motor_on_n),
    .motor_on_oe(motor_on_oe), .drive_sel_n(drive_sel_n),
    .drive_sel_oe(drive_sel_oe), .write_stream_n(write_stream_n),
    .write_stream_oe(write_stream_oe), .write_gate_n(write_gate_n),
    .write_gate_oe(write_gate_oe), .thr_write(thr_write), .tx_empty(tx_empty),
    .rx_fifo_empty(rx_fifo_empty), .rx_idle(rx_idle),
    .serial_rx_in(serial_rx_in), .ring_indicator(ring_indicator),
    .uart_tx_pd(uart_tx_pd), .uart_rx_pd(uart_rx_pd),
    .ring_change(ring_change), .epp_enabled(epp_enabled),
    .ecp_enabled(ecp_enabled), .ecr_mode(ecr_mode), .epp_pd(epp_pd),
    .ecp_pd(ecp_pd));
  apc_host_model apc_host_model_inst (.clock(clock), .io_read_strobe_n(rs_n),
    .io_write_strobe_n(ws_n), .sys_addr(sys_addr),
    .sys_data_in(sys_data_in), .sys_data_out(sys_data_out));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic [11:0] c);
    apc_host_model_inst.io_acc(c[11], c[10:8], c[7:0], q);
  endtask : acc
  task automatic wait_pd(input logic e);
    int i;
    for (i = 0; i < 80 && fdc_powered_down !== e; i++) @(negedge clock);
    if (i >= 80) begin
      chk("pd_wait", e, fdc_powered_down);
      end_of_test();
    end
  endtask : wait_pd
  task automatic t_sleep();
    @(posedge clock);
    auto_power_cfg <= 8'h01;
    core_drq <= 1'b1;
    repeat (30) @(negedge clock);
    chk("pd_head_loaded", 0, fdc_powered_down);
    head_unloaded <= 1'b1;
    wait_pd(1'b1);
    chk("dma_req", 0, dma_req);
    chk("fdd_oe", 0, {motor_on_oe, drive_sel_oe, write_stream_oe,
        write_gate_oe});
    chk("fdd_pins", 6'h3f, {motor_on_n, drive_sel_n, write_stream_n,
        write_gate_n});
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_quiet();
    logic [11:0] tbl [6] = '{12'h0a5, 12'h1b6, 12'h7c7, 12'hf03, 12'ha0c,
        12'hc01};
    int o0;
    o0 = n_oe;
    foreach (tbl[i]) begin
      acc(tbl[i]);
      if (!tbl[i][11]) chk("rd_data", tbl[i][7:0], q);
      chk("pd_quiet", 1, fdc_powered_down);
    end
    chk("xfer", 8'h03, xfer_value);
    chk("doc", 8'h0c, doc_value);
    chk("rate", 8'h01, rate_value);
    chk("oe_cycles", 9, n_oe - o0);
    $display("test quiet done");
  endtask : t_quiet
  task automatic t_wake();
    logic [11:0] tbl [5] = '{12'h480, 12'h500, 12'hd55, 12'ha14, 12'hc82};
    int w0, s0;
    w0 = n_wake;
    s0 = n_srst;
    foreach (tbl[i]) begin
      wait_pd(1'b1);
      acc(tbl[i]);
      chk("pd_woken", 0, fdc_powered_down);
      if (i == 0) chk("main_rd", APC_MAIN_IDLE, q);
      repeat (10) @(negedge clock);
      chk("pd_restart", 0, fdc_powered_down);
      if (i == 3) acc(12'ha04);
    end
    wait_pd(1'b1);
    bus_reset <= 1'b1;
    repeat (2) @(negedge clock);
    bus_reset <= 1'b0;
    chk("pd_bus_reset", 0, fdc_powered_down);
    wait_pd(1'b1);
    chk("wake_pulses", 7, n_wake - w0);
    chk("soft_resets", 1, n_srst - s0);
    auto_power_cfg <= 8'h00;
    repeat (30) @(negedge clock);
    chk("pd_cfg_off", 0, fdc_powered_down);
    core_int <= 1'b1;
    @(negedge clock);
    chk("irq_awake", 2'b11, {irq_out, dma_req});
    core_int <= 1'b0;
    $display("test wake done");
  endtask : t_wake
  task automatic t_uart();
    logic seen_rx, seen_ri;
    tx_empty <= 2'h3;
    rx_fifo_empty <= 2'h3;
    rx_idle <= 2'h3;
    repeat (5) @(negedge clock);
    chk("uart_off", 0, {uart_tx_pd, uart_rx_pd});
    auto_power_cfg <= 8'h30;
    repeat (5) @(negedge clock);
    chk("uart_on", 8'h0f, {uart_tx_pd, uart_rx_pd});
    thr_write[0] <= 1'b1;
    tx_empty[0] <= 1'b0;
    rx_fifo_empty[1] <= 1'b0;
    @(negedge clock);
    thr_write[0] <= 1'b0;
    serial_rx_in[0] <= 1'b0;
    ring_indicator[1] <= 1'b0;
    seen_rx = 0;
    seen_ri = 0;
    repeat (8) begin
      @(negedge clock);
      seen_rx |= ~uart_rx_pd[0];
      seen_ri |= ring_change[1];
    end
    chk("tx_woken", 8'h2, uart_tx_pd);
    chk("rx1_fifo", 0, uart_rx_pd[1]);
    chk("rx_woken", 1, seen_rx);
    chk("ring_flag", 1, seen_ri);
    $display("test uart done");
  endtask : t_uart
  task automatic t_par();
    logic [5:0] m;
    logic e, c;
    for (int i = 0; i < 64; i++) begin
      m = i[5:0];
      auto_power_cfg <= {4'h0, m[5], 3'h0};
      epp_enabled <= m[4];
      ecp_enabled <= m[3];
      ecr_mode <= m[2:0];
      repeat (3) @(negedge clock);
      e = m[5] && (!m[4] || (m[3] && m[2:0] != APC_ECR_EPP));
      c = m[5] && (!m[3] || m[2:0] inside {APC_ECR_SPP, APC_ECR_BIDIR,
          APC_ECR_EPP});
      chk("par_pd", {e, c}, {epp_pd, ecp_pd});
    end
    $display("test parallel done");
  endtask : t_par
  task automatic t_smi();
    for (int i = 0; i < 4; i++) begin
      smi_enable2 <= {i[1], i[0], 6'h00};
      smi_event <= 1'b1;
      repeat (3) @(negedge clock);
      chk("smi_on", i[1:0], {sys_mgmt_irq, smi_to_serirq});
      smi_event <= 1'b0;
      repeat (3) @(negedge clock);
      chk("smi_off", 0, {sys_mgmt_irq, smi_to_serirq});
    end
    $display("test smi done");
  endtask : t_smi
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {resetn, bus_reset, smi_event, core_int, core_drq, head_unloaded} = '0;
    {epp_enabled, ecp_enabled, ecr_mode, auto_power_cfg, smi_enable2} = '0;
    {core_write_stream_n, core_write_gate_n} = 2'h3;
    {core_motor_on_n, core_drive_sel_n} = 4'hf;
    {thr_write, tx_empty, rx_fifo_empty, rx_idle} = '0;
    serial_rx_in = 2'h3;
    ring_indicator = 2'h3;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk("regs_reset", 8'h42, {doc_value[3:0], rate_value[3:0]});
    chk("xfer_reset", 0, {xfer_value, fdc_powered_down});
    t_sleep();
    t_quiet();
    t_wake();
    t_uart();
    t_par();
    t_smi();
    end_of_test();
  end
endmodule : tb_top
